//--- dv/rpsr_bench.sv
// Purpose: self-checking bench for rpsr_top
// Assumes: tick of 10 clocks, lower limit 100
// Notes:   each power-up is a fresh reset
`timescale 1ns/100ps
module rpsr_bench;
  import rpsr_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_rq;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, q, lfsr = 32'h00016ed7;
  logic        init_done = 1'b0, lost = 1'b0, start_ok = 1'b1, run_req = 1'b0, run_term;
  logic [15:0] set_req = 16'h0000, set_freq, run_freq, ssdt, lim = 16'h0064;
  logic        term_ch = 1'b1;
  rpsr_ctl_t   ctl;
  int          miscompares = 0, n_compared = 0, n;
  logic [4:0]  ra [6] = '{OFS_CTRL, OFS_SSDT, OFS_WAKE, OFS_RWAIT, OFS_SDLY, 5'h18};
  logic [15:0] rv [6] = '{16'h0, 16'h0032, 16'h0, 16'h000a, 16'h0, 16'h0};
  logic [7:0]  acts [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12};
  ////////////////////////////////////////
  rpsr_top #(.TICK_CYCLES(10)) dut_u (.clk(clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .term_channel(term_ch), .run_term(run_term),
    .init_done(init_done), .power_lost(lost), .start_ok(start_ok), .set_freq(set_freq),
    .run_freq(run_freq), .lower_limit(lim), .drive_ctl(ctl), .stop_speed_detect_time(ssdt));
  rpsr_far_model far_u (.clk(clk), .run_req(run_req), .set_req(set_req),
    .run_term(run_term), .set_freq(set_freq), .run_freq(run_freq));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] f_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // writes above the top of range are clipped, not refused
  function automatic logic [31:0] f_clip(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = (a == OFS_SSDT) ? MAX_SSDT : MAX_TENTHS;
    return {16'h0, (d > m) ? m : d};
  endfunction
  task automatic close_out();
    $display("counts: %0d compared, %0d unexpected", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i = 0;
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do begin
      @(posedge clk);
      i++;
    end while (wait_rq !== 1'b0 && i < 20);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (i >= 20) begin miscompares++; close_out(); end
  endtask
  task automatic wt(input int b, input logic v, input int lim_c);
    n = 0;
    while (ctl[b] !== v && n < lim_c) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim_c) begin miscompares++; close_out(); end
  endtask
  task automatic pwr(input logic [31:0] c, input logic term, input logic pl);
    rst_n     <= 1'b0;
    init_done <= 1'b0;
    run_req   <= term;
    lost      <= pl;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, OFS_CTRL, c);
    init_done <= 1'b1;
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    pwr(32'h0, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, {16'h0, rv[i]});
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = f_lfsr(lfsr);
      bus(1'b1, ra[1 + i % 4], lfsr);
      bus(1'b0, ra[1 + i % 4], 32'h0);
      chk(q, f_clip(ra[1 + i % 4], lfsr[15:0]));
    end
    bus(1'b1, OFS_SSDT, 32'hffff);
    chk({16'h0, ssdt}, 32'h2710);
    $display("test registers end");
    pwr(32'h0, 1'b1, 1'b0);
    repeat (5) @(posedge clk);
    chk({27'h0, ctl}, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h00000021);
    run_req <= 1'b0;
    repeat (3) @(posedge clk);
    run_req <= 1'b1;
    wt(4, 1'b1, 20);
    chk({31'h0, ctl.protect}, 32'h0);
    pwr(32'h1, 1'b1, 1'b0);
    wt(4, 1'b1, 20);
    chk({31'h0, ctl.protect}, 32'h0);
    pwr(32'h2, 1'b1, 1'b0);
    wt(4, 1'b1, 20);
    chk({31'h0, ctl.protect}, 32'h0);
    term_ch <= 1'b0;
    pwr(32'h0, 1'b1, 1'b0);
    wt(4, 1'b1, 20);
    chk({31'h0, ctl.protect}, 32'h0);
    term_ch <= 1'b1;
    $display("test power-up end");
    start_ok <= 1'b0;
    pwr(32'h2, 1'b1, 1'b1);
    repeat (1100) @(posedge clk);
    chk({27'h0, ctl}, 32'h0);
    start_ok <= 1'b1;
    wt(4, 1'b1, 1200);
    chk({31'h0, n >= 985 && n <= 1012}, 32'h1);
    $display("test restart end");
    for (int i = 0; i < 6; i++) begin
      lfsr = f_lfsr(lfsr);
      set_req <= 16'h0065 + {8'h0, lfsr[7:0]};
      pwr({16'h0, acts[i], 8'h01}, 1'b1, 1'b0);
      wt(4, 1'b1, 20);
      bus(1'b1, OFS_WAKE, 32'h2);
      bus(1'b1, OFS_SDLY, 32'h1);
      set_req <= {8'h0, lfsr[15:8]} % 16'h0064;
      if (acts[i][3:0] == ACT_LIMIT) begin
        wt(3, 1'b1, 400);
        chk({31'h0, ctl.run_en}, 32'h1);
      end else begin
        wt(acts[i][0] ? 4 : 1, !acts[i][0], 400);
        chk({31'h0, ctl.decel_stop}, {31'h0, acts[i][4]});
        set_req <= 16'h00c8;
        repeat (100) @(posedge clk);
        set_req <= 16'h0032;
        repeat (3) @(posedge clk);
        set_req <= 16'h00c8;
        wt(4, 1'b1, 600);
        chk({31'h0, n >= 270 && n <= 320}, 32'h1);
      end
    end
    lim     <= 16'h0000;
    set_req <= 16'h0000;
    repeat (300) @(posedge clk);
    chk({27'h0, ctl}, 32'h14);
    $display("test below-limit end");
    close_out();
  end
endmodule

//--- dv/rpsr_checker.sv
// Purpose: port assertions for rpsr_top
// Assumes: one clock, rst_n async active low
// Notes:   bound into every rpsr_top instance
`timescale 1ns/100ps
module rpsr_checker
  import rpsr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        run_term,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] run_freq,
  input wire logic [15:0] lower_limit,
  input wire rpsr_ctl_t   drive_ctl,
  input wire logic [15:0] stop_speed_detect_time
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_ssdt; stop_speed_detect_time <= MAX_SSDT; endproperty
  a_ssdt: assert property (p_ssdt) else $error("ssdt over max");
  property p_prot; drive_ctl.protect |-> !drive_ctl.run_en; endproperty
  a_prot: assert property (p_prot) else $error("run in protect");
  property p_unprot; $fell(drive_ctl.protect) |-> $past(run_term); endproperty
  a_unprot: assert property (p_unprot) else $error("protect left");
  property p_go; $rose(drive_ctl.run_en) |-> $past(run_term); endproperty
  a_go: assert property (p_go) else $error("run w/o cmd");
  property p_halt; !run_term |=> !drive_ctl.run_en; endproperty
  a_halt: assert property (p_halt) else $error("run after drop");
  property p_clamp; drive_ctl.clamp_low |-> drive_ctl.run_en && $past(set_freq < lower_limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp idle");
  property p_nap; $rose(drive_ctl.sleeping) |-> $past(run_freq < lower_limit); endproperty
  a_nap: assert property (p_nap) else $error("sleep cause");
  property p_wake; $fell(drive_ctl.sleeping) |-> $past(set_freq > lower_limit || !run_term);
  endproperty
  a_wake: assert property (p_wake) else $error("wake cause");
endmodule
bind rpsr_top rpsr_checker chk_u (.clk(clk), .rst_n(rst_n), .run_term(run_term),
  .set_freq(set_freq), .run_freq(run_freq), .lower_limit(lower_limit),
  .drive_ctl(drive_ctl), .stop_speed_detect_time(stop_speed_detect_time));

//--- dv/rpsr_far_model.sv
// Purpose: run terminal and setpoint source
// Assumes: bench sets the requests
// Notes:   run_freq ramps one unit a clock, like a slow load
`timescale 1ns/100ps
module rpsr_far_model (
  input  wire logic        clk,
  input  wire logic        run_req,
  input  wire logic [15:0] set_req,
  output logic             run_term = 1'b0,
  output logic      [15:0] set_freq = 16'h0000,
  output logic      [15:0] run_freq = 16'h0000
);
  always @(posedge clk) begin
    run_term <= run_req;
    set_freq <= set_req;
    if (run_freq < set_freq) run_freq <= run_freq + 16'h0001;
    else if (run_freq > set_freq) run_freq <= run_freq - 16'h0001;
  end
endmodule

//--- logic/rpsr_pkg.sv
// Purpose: shared constants and types for the run permit, sleep and restart block
// Assumes: 100 MHz clock, 10 ms timer tick
// Notes:   register offsets are byte addresses on the avalon slave
package rpsr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 10_000_000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_SSDT   = 5'h04;
  localparam logic [4:0] OFS_WAKE   = 5'h08;
  localparam logic [4:0] OFS_RWAIT  = 5'h0c;
  localparam logic [4:0] OFS_SDLY   = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // ctrl fields
  localparam int CTRL_PROT_BIT = 0;
  localparam int CTRL_RST_BIT  = 1;
  localparam int CTRL_ACT_LSB  = 8;

  // reset values, times in hundredths (ssdt) or tenths of a second
  localparam logic        RST_PROTECT = 1'b0;
  localparam logic        RST_RESTART = 1'b0;
  localparam logic [7:0]  RST_ACTION  = 8'h00;
  localparam logic [15:0] RST_SSDT    = 16'h0032;
  localparam logic [15:0] RST_WAKE    = 16'h0000;
  localparam logic [15:0] RST_RWAIT   = 16'h000a;
  localparam logic [15:0] RST_SDLY    = 16'h0000;

  localparam logic [15:0] MAX_SSDT    = 16'h2710;
  localparam logic [15:0] MAX_TENTHS  = 16'h8ca0;
  localparam logic [3:0]  MAX_ACT_ONE = 4'h2;
  localparam logic [3:0]  MAX_ACT_TEN = 4'h1;

  localparam logic [3:0]  ACT_LIMIT   = 4'h0;
  localparam logic [3:0]  ACT_STOP    = 4'h1;
  localparam logic [3:0]  ACT_SLEEP   = 4'h2;

  localparam logic [19:0] TMR_MAX     = 20'hfffff;
  localparam logic [19:0] TICKS_PER_T = 20'h0000a;

  typedef struct packed {
    logic        protect;
    logic        restart_en;
    logic [7:0]  action;
    logic [15:0] ssdt;
    logic [15:0] wake;
    logic [15:0] rwait;
    logic [15:0] sdly;
  } rpsr_cfg_t;

  typedef struct packed {
    logic run_en;
    logic clamp_low;
    logic decel_stop;
    logic sleeping;
    logic protect;
  } rpsr_ctl_t;

  typedef enum logic [2:0] {
    ST_PWRUP, ST_PROT, ST_IDLE, ST_RWAIT, ST_SDLY, ST_RUN, ST_STOPW, ST_SLEEP
  } rpsr_state_t;
endpackage

//--- logic/rpsr_top.sv
// Purpose: start/stop qualification for a drive: power-up protection,
//          below-limit action, wake from sleep, restart after power loss
// Assumes: inputs synchronous to clk; rst_n marks power-up
// Notes:   avalon-mm slave, one wait cycle per access
//
// Contract
// - hold stop speed detect time, 0 to 100.00 s in hundredths, default 0.50 s.
// - with terminal run source, sample run terminal during power-up.
// - protect setting 0 and terminal active at power-up: refuse, enter protection.
// - in protection, start only after terminal drops and rises again.
// - protect value 0 applies only when power-loss restart setting is 0.
// - protect setting 1: auto start after init if terminal was active.
// - below-limit action ones digit: 0 run at limit, 1 stop, 2 sleep.
// - on stop or sleep, tens digit: 0 coast, 1 decelerate.
// - resume when set frequency stays above limit for the wake delay.
// - sleep action: enter sleep when running frequency below limit; wake default 0.
// - restart setting 1: run automatically at power-on after power loss.
// - restart only after wait time (default 1 s) and start conditions met.
// - after a run command or wake, delay output by the start delay.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module rpsr_top
  import rpsr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        term_channel,
  input  wire logic        run_term,
  input  wire logic        init_done,
  input  wire logic        power_lost,
  input  wire logic        start_ok,
  input  wire logic [15:0] set_freq,
  input  wire logic [15:0] run_freq,
  input  wire logic [15:0] lower_limit,
  output rpsr_ctl_t        drive_ctl,
  output logic      [15:0] stop_speed_detect_time
);

  function automatic logic [19:0] to_ticks(input logic [15:0] tenths);
    to_ticks = 20'(tenths) * TICKS_PER_T;
  endfunction

  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] m);
    clip = (v > m) ? m : v;
  endfunction

  // a zero lower limit disables the below-limit action
  function automatic logic below(input logic [15:0] f, input logic [15:0] lim);
    below = (lim != 16'h0000) && (f < lim);
  endfunction

  // a partial tick may already be counted, so delays run short by at most one tick
  function automatic logic elapsed(input logic [19:0] t, input logic [15:0] tenths);
    elapsed = (t >= to_ticks(tenths));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  rpsr_cfg_t   cfg_reg;
  rpsr_cfg_t   cfg_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  rpsr_state_t st_reg;
  logic [31:0] status_word;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign stop_speed_detect_time = cfg_reg.ssdt;

  always_comb begin
    status_word = {24'h000000, drive_ctl.run_en, drive_ctl.sleeping,
                   drive_ctl.protect, drive_ctl.clamp_low, drive_ctl.decel_stop, st_reg};
  end

  always_comb begin
    cfg_next   = cfg_reg;
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      unique case (avs_address)
        OFS_CTRL:   rdata_next = {16'h0000, cfg_reg.action, 6'h00,
                                  cfg_reg.restart_en, cfg_reg.protect};
        OFS_SSDT:   rdata_next = {16'h0000, cfg_reg.ssdt};
        OFS_WAKE:   rdata_next = {16'h0000, cfg_reg.wake};
        OFS_RWAIT:  rdata_next = {16'h0000, cfg_reg.rwait};
        OFS_SDLY:   rdata_next = {16'h0000, cfg_reg.sdly};
        OFS_STATUS: rdata_next = status_word;
        default:    rdata_next = 32'h00000000;
      endcase
    end
    // write lands on the edge where waitrequest is low
    if (avs_write && ack_reg) begin
      unique case (avs_address)
        OFS_CTRL: begin
          cfg_next.protect    = avs_writedata[CTRL_PROT_BIT];
          cfg_next.restart_en = avs_writedata[CTRL_RST_BIT];
          // an out-of-range action code keeps the previous one
          if (avs_writedata[CTRL_ACT_LSB+3:CTRL_ACT_LSB] <= MAX_ACT_ONE &&
              avs_writedata[CTRL_ACT_LSB+7:CTRL_ACT_LSB+4] <= MAX_ACT_TEN) begin
            cfg_next.action = avs_writedata[CTRL_ACT_LSB+7:CTRL_ACT_LSB];
          end
        end
        OFS_SSDT:  cfg_next.ssdt  = clip(avs_writedata[15:0], MAX_SSDT);
        OFS_WAKE:  cfg_next.wake  = clip(avs_writedata[15:0], MAX_TENTHS);
        OFS_RWAIT: cfg_next.rwait = clip(avs_writedata[15:0], MAX_TENTHS);
        OFS_SDLY:  cfg_next.sdly  = clip(avs_writedata[15:0], MAX_TENTHS);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= '{protect: RST_PROTECT, restart_en: RST_RESTART,
                     action: RST_ACTION, ssdt: RST_SSDT, wake: RST_WAKE,
                     rwait: RST_RWAIT, sdly: RST_SDLY};
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      cfg_reg   <= cfg_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run qualification

  rpsr_state_t st_next;
  logic [19:0] tmr_reg;
  logic [19:0] tmr_next;
  logic [31:0] pre_reg;
  logic [31:0] pre_next;
  logic        tick;
  logic        low_seen_reg;
  logic        low_seen_next;
  logic        term_pwr_reg;
  logic        term_pwr_next;
  rpsr_ctl_t   ctl_reg;
  rpsr_ctl_t   ctl_next;
  logic        set_below;
  logic        run_below;
  logic        set_above;
  logic [3:0]  act_one;

  assign drive_ctl = ctl_reg;

  always_comb begin
    act_one   = cfg_reg.action[3:0];
    set_below = below(set_freq, lower_limit);
    run_below = below(run_freq, lower_limit);
    set_above = set_freq > lower_limit;
  end

  always_comb begin
    st_next       = st_reg;
    tmr_next      = tmr_reg;
    low_seen_next = low_seen_reg;
    term_pwr_next = term_pwr_reg;
    tick          = (pre_reg == 32'(TICK_CYCLES - 1));
    pre_next      = tick ? 32'h00000000 : pre_reg + 32'h00000001;
    if (tick && tmr_reg != TMR_MAX) begin
      tmr_next = tmr_reg + 20'h00001;
    end
    unique case (st_reg)
      ST_PWRUP: begin
        term_pwr_next = term_channel & run_term;
        if (init_done) begin
          if (cfg_reg.restart_en && power_lost) begin
            st_next = ST_RWAIT;
          end else if (term_pwr_reg) begin
            // a set restart bit overrides protect value 0
            st_next = (cfg_reg.protect || cfg_reg.restart_en) ? ST_SDLY : ST_PROT;
          end else begin
            st_next = ST_IDLE;
          end
        end
      end
      ST_PROT: begin
        if (!run_term) begin
          low_seen_next = 1'b1;
        end
        if (low_seen_reg && run_term) begin
          st_next = ST_SDLY;
        end
      end
      ST_IDLE: begin
        if (run_term) begin
          st_next = ST_SDLY;
        end
      end
      ST_RWAIT: begin
        if (!start_ok || !run_term) begin
          tmr_next = 20'h00000;
        end else if (elapsed(tmr_reg, cfg_reg.rwait)) begin
          st_next = ST_SDLY;
        end
      end
      ST_SDLY: begin
        if (!run_term) begin
          st_next = ST_IDLE;
        end else if (elapsed(tmr_reg, cfg_reg.sdly)) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_term) begin
          st_next = ST_IDLE;
        end else if (set_below && act_one == ACT_STOP) begin
          st_next = ST_STOPW;
        end else if (run_below && act_one == ACT_SLEEP) begin
          st_next = ST_SLEEP;
        end
      end
      ST_STOPW, ST_SLEEP: begin
        if (!run_term) begin
          st_next = ST_IDLE;
        end else if (!set_above) begin
          tmr_next = 20'h00000;
        end else if (elapsed(tmr_reg, cfg_reg.wake)) begin
          st_next = ST_SDLY;
        end
      end
    endcase
    // every timed phase starts from zero
    if (st_next != st_reg) begin
      tmr_next      = 20'h00000;
      low_seen_next = 1'b0;
    end
    ctl_next.run_en     = (st_next == ST_RUN);
    ctl_next.clamp_low  = (st_next == ST_RUN) && set_below && act_one == ACT_LIMIT;
    ctl_next.decel_stop = cfg_reg.action[4];
    ctl_next.sleeping   = (st_next == ST_SLEEP);
    ctl_next.protect    = (st_next == ST_PROT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= ST_PWRUP;
      tmr_reg      <= 20'h00000;
      pre_reg      <= 32'h00000000;
      low_seen_reg <= 1'b0;
      term_pwr_reg <= 1'b0;
      ctl_reg      <= '0;
    end else begin
      st_reg       <= st_next;
      tmr_reg      <= tmr_next;
      pre_reg      <= pre_next;
      low_seen_reg <= low_seen_next;
      term_pwr_reg <= term_pwr_next;
      ctl_reg      <= ctl_next;
    end
  end

endmodule
